/* srs_pkg.sv */
// Shared constants, types and register map of the two-wire register access slave
package srs_pkg;

    // Clock rate and bus inactivity timeout
    localparam int CLK_HZ = 40_000_000;          // System clock rate in Hz
    localparam int TIMEOUT_MS = 25;              // Bus inactivity timeout in ms
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000); // Timeout in clock cycles

    // Fixed bus addresses of the two variants
    localparam logic [6:0] ADDR_STD = 7'h4C;     // Standard variant address
    localparam logic [6:0] ADDR_ALT = 7'h4D;     // Alternate variant address

    // Frame layout
    localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Data bits before the acknowledge slot
    localparam logic [1:0] MAX_WR_BYTES = 2'h2;  // Bytes a write may carry after the address

    // Register pointer values with special meaning
    localparam logic [7:0] PTR_ONE_SHOT = 8'h0F;     // Write strobe that starts a measurement
    localparam logic [7:0] PTR_ALERT_CFG = 8'h22;    // Alert count and timeout config
    localparam int TIMEOUT_EN_BIT = 7;               // Timeout enable bit in alert config

    // Read-only and shadowed addresses
    localparam logic [7:0] RD_LOCAL = 8'h00;     // Local temperature value
    localparam logic [7:0] RD_REM_HI = 8'h01;    // Remote temperature high byte
    localparam logic [7:0] RD_STATUS = 8'h02;    // Status byte
    localparam logic [7:0] RD_REM_LO = 8'h10;    // Remote temperature low byte
    localparam logic [7:0] RD_ID = 8'hFE;        // Identification byte
    localparam logic [7:0] RD_SPLIT_LO = 8'h03;  // First read address with a distinct write address
    localparam logic [7:0] RD_SPLIT_HI = 8'h08;  // Last read address with a distinct write address
    localparam logic [7:0] RD_TO_WR = 8'h06;     // Distance from read address to write address
    localparam logic [7:0] ID_VALUE = 8'h5A;     // Identification value, arbitrary

    // Size of the stored register space
    localparam int REG_DEPTH = 64;               // Stored entries, indexed by pointer bits 5..0
    localparam logic [7:0] REG_LIMIT = 8'h40;    // Pointer values below this may be stored

    // Value written to a writable address after reset
    function automatic logic [7:0] reg_default(input logic [7:0] a);
        case (a)
            8'h0A: reg_default = 8'h08;          // Conversion rate
            8'h0B: reg_default = 8'h55;          // Local high limit
            8'h0D: reg_default = 8'h55;          // Remote high limit, high byte
            8'h19: reg_default = 8'h6C;          // Remote therm limit
            8'h20: reg_default = 8'h55;          // Local therm limit
            8'h21: reg_default = 8'h0A;          // Therm hysteresis
            8'h22: reg_default = 8'h01;          // Alert count, timeout disabled
            default: reg_default = 8'h00;
        endcase
    endfunction

    // True for addresses that accept a data write
    function automatic logic reg_writable(input logic [7:0] a);
        reg_writable = (a >= 8'h09 && a <= 8'h0E) || (a >= 8'h11 && a <= 8'h14) ||
                       (a >= 8'h19 && a <= 8'h22);
    endfunction

    // Measurement results supplied by the sensing logic
    typedef struct packed {
        logic [7:0] local_temp;   // Local temperature value
        logic [7:0] remote_hi;    // Remote temperature high byte
        logic [7:0] status;       // Status byte
        logic [7:0] remote_lo;    // Remote temperature low byte
    } srs_sense_s;

    // Data write notice passed to the register consumers
    typedef struct packed {
        logic valid;              // One-cycle pulse
        logic [7:0] addr;         // Write address
        logic [7:0] data;         // Written value
    } srs_write_s;

endpackage

/* srs_sync2.sv */
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps

module srs_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic async_i,
    output logic sync_o
);

    logic meta_q; // First stage, read only by the second stage

    // Two flops; pins idle high so both reset to one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_o <= 1'b1;
        end else if (ce) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

/* srs_slave.sv */
// Two-wire bus slave with register pointer, register store and measurement strobe
`timescale 1ns/1ps

// Each bus pin passes two flops, so every bus clock half
// period must last several clk periods or bits are missed.
// The pointer has no reset; early reads return junk.
// A read returns one byte; extra clocks wait for a start.
// With the timeout off, a stuck master holds the slave
// mid-frame until the next start or stop.

module srs_slave #(
    parameter bit ALT_VARIANT = 1'b0,                  // Selects the alternate bus address
    parameter int TIMEOUT_CYC = srs_pkg::TIMEOUT_CYC   // Idle cycles before the bus is dropped
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bus_clock_line_i,
    input wire logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe,
    input wire srs_pkg::srs_sense_s sense_i,
    output logic one_shot_q,
    output srs_pkg::srs_write_s wr_q,
    output logic timeout_en_q
);

    // Bus states
    typedef enum logic [2:0] {
        S_IDLE,      // Waiting for a start
        S_ADDR,      // Shifting in address and direction
        S_ADDR_ACK,  // Driving the address acknowledge
        S_WR,        // Receiving a byte from the master
        S_WR_ACK,    // Acknowledge slot after a received byte
        S_RD,        // Sending the read byte
        S_RD_ACK     // Master acknowledge slot after the read byte
    } srs_state_e;

    // Own address picked by variant
    // Fixed at build time; no pin selects it
    localparam logic [6:0] OWN_ADDR = ALT_VARIANT ? srs_pkg::ADDR_ALT : srs_pkg::ADDR_STD;

    // Pin sampling and bus conditions
    logic scl_s;                  // Synchronised clock line
    logic sda_s;                  // Synchronised data line
    logic scl_d_q;                // Clock line one cycle older
    logic sda_d_q;                // Data line one cycle older
    logic scl_rise;               // Clock line rose
    logic scl_fall;               // Clock line fell
    logic start_det;              // Start condition seen
    logic stop_det;               // Stop condition seen
    logic bus_change;             // Any line moved
    // Frame progress
    srs_state_e state_q;          // Bus state
    logic [3:0] bit_cnt_q;        // Clock pulses counted in this byte
    logic [7:0] shift_q;          // Receive and transmit shift register
    logic rw_q;                   // Direction of the current operation
    logic [1:0] byte_idx_q;       // Bytes received after the address
    // Register side
    logic [7:0] ptr_q;            // Register pointer
    logic [7:0] regs_q [0:srs_pkg::REG_DEPTH-1]; // Stored registers
    // Inactivity watch
    logic [19:0] idle_cnt_q;      // Cycles without bus movement
    logic timeout_hit;            // Inactivity limit reached
    logic wr_byte_done;           // Eighth bit of a received byte ended
    logic [7:0] rd_value;         // Byte returned for the current pointer
    logic [7:0] rd_index;         // Stored entry shadowing a read address

    // Pin inputs pass two flops before any logic sees them
    // The first stages feed nothing but the second
    srs_sync2 u_sync_scl (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_i(bus_clock_line_i),
        .sync_o(scl_s)
    );

    srs_sync2 u_sync_sda (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_i(bus_data_line_i),
        .sync_o(sda_s)
    );

    // Previous line levels for edge finding
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else if (ce) begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    // Edge and condition decode
    // Start and stop need the clock high on both samples, so
    // a data edge racing a clock edge is never a condition
    always_comb begin
        scl_rise = scl_s & ~scl_d_q;
        scl_fall = ~scl_s & scl_d_q;
        start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
        stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;
        bus_change = (scl_s != scl_d_q) || (sda_s != sda_d_q);
        wr_byte_done = (state_q == S_WR) && scl_fall && (bit_cnt_q == srs_pkg::BITS_PER_BYTE);
    end

    // Read data selection, split registers read through their write entry
    // Write-only and unmapped addresses read as zero
    always_comb begin
        rd_index = 8'(ptr_q + srs_pkg::RD_TO_WR);
        if (ptr_q >= srs_pkg::RD_SPLIT_LO && ptr_q <= srs_pkg::RD_SPLIT_HI) begin
            rd_value = regs_q[rd_index[5:0]];
        end else if (ptr_q == srs_pkg::RD_LOCAL) begin
            rd_value = sense_i.local_temp;
        end else if (ptr_q == srs_pkg::RD_REM_HI) begin
            rd_value = sense_i.remote_hi;
        end else if (ptr_q == srs_pkg::RD_STATUS) begin
            rd_value = sense_i.status;
        end else if (ptr_q == srs_pkg::RD_REM_LO) begin
            rd_value = sense_i.remote_lo;
        end else if (ptr_q == srs_pkg::RD_ID) begin
            rd_value = srs_pkg::ID_VALUE;
        end else if (srs_pkg::reg_writable(ptr_q) && ptr_q >= 8'h11) begin
            rd_value = regs_q[ptr_q[5:0]];                   // Same read and write address
        end else begin
            rd_value = 8'h00;                                // Write-only or unmapped
        end
    end

    // Inactivity counter, cleared by any line movement or while idle
    // With the timeout enabled, counting halts at the limit until idle clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_cnt_q <= 20'h00000;
        end else if (ce) begin
            if (state_q == S_IDLE || bus_change) begin
                idle_cnt_q <= 20'h00000;
            end else if (!timeout_hit) begin
                idle_cnt_q <= idle_cnt_q + 20'h00001;
            end
        end
    end

    // Timeout fires only when enabled by config bit 7
    assign timeout_hit = timeout_en_q && (idle_cnt_q == 20'(TIMEOUT_CYC - 1));

    // Bus state machine, bit counting, shifting and data line drive
    // Bits are taken on the rising clock and driven after the
    // falling one, so the line only moves while the clock is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            byte_idx_q <= 2'h0;
            bus_data_line_oe <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                // A start, repeated or not, restarts the address phase
                // Byte count starts afresh
                state_q <= S_ADDR;
                bit_cnt_q <= 4'h0;
                byte_idx_q <= 2'h0;
                bus_data_line_oe <= 1'b0;
            end else if (stop_det || timeout_hit) begin
                // Stop or timeout drops the frame and frees the line
                // A start in the same cycle wins
                state_q <= S_IDLE;
                bus_data_line_oe <= 1'b0;
            end else begin
                case (state_q)
                    S_ADDR: begin
                        // Sample each bit on the rising clock, MSB first
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == srs_pkg::BITS_PER_BYTE) begin
                            if (shift_q[7:1] == OWN_ADDR) begin
                                bus_data_line_oe <= 1'b1;
                                rw_q <= shift_q[0];
                                state_q <= S_ADDR_ACK;
                            end else begin
                                // Not ours: stay off the bus
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_ADDR_ACK: begin
                        // Ninth pulse done; set up the data phase
                        // A read shows bit 7 at once
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rw_q) begin
                                shift_q <= rd_value;
                                bus_data_line_oe <= ~rd_value[7];
                                state_q <= S_RD;
                            end else begin
                                bus_data_line_oe <= 1'b0;
                                state_q <= S_WR;
                            end
                        end
                    end
                    S_WR: begin
                        // Receive a byte, then acknowledge only the first two
                        // A third byte gets no acknowledge
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (wr_byte_done) begin
                            bus_data_line_oe <= (byte_idx_q < srs_pkg::MAX_WR_BYTES);
                            if (byte_idx_q < srs_pkg::MAX_WR_BYTES) begin
                                byte_idx_q <= byte_idx_q + 2'h1;
                            end
                            state_q <= S_WR_ACK;
                        end
                    end
                    S_WR_ACK: begin
                        // Release after the acknowledge pulse
                        // Then wait for the next byte
                        if (scl_fall) begin
                            bus_data_line_oe <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            state_q <= S_WR;
                        end
                    end
                    S_RD: begin
                        // Present the next bit after each falling clock
                        // Free the line after bit 8
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == srs_pkg::BITS_PER_BYTE) begin
                                bus_data_line_oe <= 1'b0;
                                state_q <= S_RD_ACK;
                            end else begin
                                shift_q <= {shift_q[6:0], 1'b0};
                                bus_data_line_oe <= ~shift_q[6];
                            end
                        end
                    end
                    S_RD_ACK: begin
                        // One byte per read; ignore the rest until a start
                        // The read ends here
                        if (scl_rise) begin
                            state_q <= S_IDLE;
                        end
                    end
                    S_IDLE: begin
                        // Line stays free when unaddressed
                        bus_data_line_oe <= 1'b0;
                    end
                    default: begin
                        // Unused codes fall back to idle
                        state_q <= S_IDLE;
                        bus_data_line_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Data line only ever pulled low
    // Only the enable carries information
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_data_line_o <= 1'b0;
        end else if (ce) begin
            bus_data_line_o <= 1'b0;
        end
    end

    // Pointer loads from the first written byte and is never reset
    // No reset keeps its power-on value undefined
    always_ff @(posedge clk) begin
        if (ce && wr_byte_done && byte_idx_q == 2'h0) begin
            ptr_q <= shift_q;
        end
    end

    // Register store, measurement strobe and write notice
    // Only the second write byte lands; the strobe address
    // and read-only or unmapped pointers keep nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < srs_pkg::REG_DEPTH; i++) begin
                regs_q[i] <= srs_pkg::reg_default(8'(i));
            end
            one_shot_q <= 1'b0;
            wr_q <= '0;
        end else if (ce) begin
            one_shot_q <= 1'b0;
            wr_q.valid <= 1'b0;
            if (wr_byte_done && byte_idx_q == 2'h1) begin
                if (ptr_q == srs_pkg::PTR_ONE_SHOT) begin
                    one_shot_q <= 1'b1;
                end else if (srs_pkg::reg_writable(ptr_q) && ptr_q < srs_pkg::REG_LIMIT) begin
                    regs_q[ptr_q[5:0]] <= shift_q;
                    wr_q.valid <= 1'b1;
                    wr_q.addr <= ptr_q;
                    wr_q.data <= shift_q;
                end
            end
        end
    end

    // Timeout enable mirrors bit 7 of the alert config, zero after reset
    // One cycle behind the store
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timeout_en_q <= 1'b0;
        end else if (ce) begin
            timeout_en_q <= regs_q[srs_pkg::PTR_ALERT_CFG[5:0]][srs_pkg::TIMEOUT_EN_BIT];
        end
    end

endmodule

/* srs_slave_properties.sv */
// Concurrent checks on the ports of the two-wire register access slave
`timescale 1ns/1ps

module srs_slave_properties #(
    parameter int TIMEOUT_CYC = srs_pkg::TIMEOUT_CYC // Idle cycles before the bus is dropped
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bus_clock_line_i,
    input wire logic bus_data_line_i,
    input wire logic bus_data_line_o,
    input wire logic bus_data_line_oe,
    input wire logic one_shot_q,
    input wire srs_pkg::srs_write_s wr_q,
    input wire logic timeout_en_q
);
    logic scl_q; // Clock pin one cycle ago
    logic sda_q; // Data pin one cycle ago
    logic [19:0] stall_q; // Cycles of pulling low on a silent bus

    // Counts how long the slave holds data low while nothing moves and the timeout is enabled
    always_ff @(posedge clk) begin
        scl_q <= bus_clock_line_i;
        sda_q <= bus_data_line_i;
        if (!rst_n || !bus_data_line_oe || !timeout_en_q || bus_clock_line_i != scl_q ||
            bus_data_line_i != sda_q) begin
            stall_q <= 20'h00000;
        end else if (stall_q != 20'hFFFFF) begin
            stall_q <= stall_q + 20'h00001;
        end
    end

    chk_drive_low: assert property (@(posedge clk) disable iff (!rst_n)
        bus_data_line_o == 1'b0) else $error("data drive value not low");
    chk_reset_quiet: assert property (@(posedge clk) disable iff (!ce)
        !rst_n |=> !bus_data_line_oe && !one_shot_q && !wr_q.valid && !timeout_en_q)
        else $error("outputs active after reset");
    chk_ack_clock_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(bus_data_line_oe) |-> !bus_clock_line_i) else $error("drive began with clock high");
    chk_release_clock_low: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(bus_data_line_oe) |-> !bus_clock_line_i) else $error("drive ended with clock high");
    chk_strobe_single: assert property (@(posedge clk) disable iff (!rst_n)
        one_shot_q |=> !one_shot_q) else $error("measurement strobe longer than one cycle");
    chk_write_single: assert property (@(posedge clk) disable iff (!rst_n)
        wr_q.valid |=> !wr_q.valid) else $error("write notice longer than one cycle");
    chk_strobe_no_store: assert property (@(posedge clk) disable iff (!rst_n)
        one_shot_q |-> !wr_q.valid && !bus_clock_line_i) else $error("strobe stored or mistimed");
    chk_write_addr: assert property (@(posedge clk) disable iff (!rst_n)
        wr_q.valid |-> wr_q.addr != 8'h0F && !bus_clock_line_i) else $error("bad write notice");
    chk_enable_source: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(timeout_en_q) |-> (wr_q.valid && wr_q.addr == 8'h22 &&
        wr_q.data[7] == timeout_en_q) || ($past(wr_q.valid) && $past(wr_q.addr) == 8'h22 &&
        $past(wr_q.data[7]) == timeout_en_q)) else $error("timeout enable changed unprompted");
    chk_timeout_bound: assert property (@(posedge clk) disable iff (!rst_n)
        stall_q <= TIMEOUT_CYC + 16) else $error("data held low past the timeout");

    cover property (@(posedge clk) wr_q.valid);
    cover property (@(posedge clk) one_shot_q);
    cover property (@(posedge clk) $fell(bus_data_line_oe) && timeout_en_q);
endmodule

/* srs_master_model.sv */
// Behavioural bus master that drives the clock pin and pulls the data pin low
`timescale 1ns/1ps

module srs_master_model (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    // Idle bus: clock stands high, data released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // One pulse: data set while clock low, sampled mid-high
    task automatic pulse(input logic b, output logic s);
        #50 sda_low_o <= !b;
        #50 scl_o <= 1'b1;
        #50 s = sda_i;
        #50 scl_o <= 1'b0;
    endtask
    // Data falls while the clock stands high
    task automatic start();
        #7 scl_o <= 1'b1;
        #100 sda_low_o <= 1'b1;
        #100 scl_o <= 1'b0;
    endtask
    // Data rises while the clock stands high
    task automatic stop();
        #50 sda_low_o <= 1'b1;
        #50 scl_o <= 1'b1;
        #50 sda_low_o <= 1'b0;
        #100;
    endtask
    // Byte out MSB first, then the slave's acknowledge slot
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], s);
        end
        pulse(1'b1, s);
        ack = !s;
    endtask
    // Byte in MSB first, then no-acknowledge
    task automatic rd_byte(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, s);
            b[i] = s;
        end
        pulse(1'b1, s);
    endtask
    // Eight bits, then the clock held low for a while
    task automatic stall(input logic [7:0] b, input int ns);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], s);
        end
        #(ns);
    endtask
endmodule

/* testbench.sv */
// Self-checking bench for the two-wire register access slave
`timescale 1ns/1ps

module testbench;
    localparam int TIMEOUT_CYC = 200; // Shortened bus timeout
    logic clk;
    logic rst_n;
    logic ce;
    logic scl; // Clock pin from the master
    logic m_low; // Master pulls data low
    wire sda; // Data wire with pull-up
    logic dut_o;
    logic dut_oe;
    logic os;
    logic ten;
    srs_pkg::srs_sense_s sense;
    srs_pkg::srs_write_s wr;
    srs_pkg::srs_write_s last_wr; // Latest write notice seen
    int fails;
    int compares;
    int wr_cnt;
    int os_cnt;

    assign sda = !(dut_oe || m_low);
    always #12.5 clk = !clk;

    srs_slave #(.ALT_VARIANT(1'b0), .TIMEOUT_CYC(TIMEOUT_CYC)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .bus_clock_line_i(scl), .bus_data_line_i(sda),
        .bus_data_line_o(dut_o), .bus_data_line_oe(dut_oe), .sense_i(sense),
        .one_shot_q(os), .wr_q(wr), .timeout_en_q(ten));
    srs_master_model m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));

    // Tallies write notices and measurement strobes
    always @(posedge clk) begin
        if (wr.valid === 1'b1) begin
            wr_cnt++;
            last_wr = wr;
        end
        if (os === 1'b1) begin
            os_cnt++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Pointer byte, with a data byte when two is set
    task automatic xfer_w(input logic [7:0] p, input logic [7:0] d, input logic two);
        logic a;
        m.start();
        m.wr_byte({srs_pkg::ADDR_STD, 1'b0}, a);
        check(a, 1'b1);
        m.wr_byte(p, a);
        check(a, 1'b1);
        if (two) begin
            m.wr_byte(d, a);
            check(a, 1'b1);
        end
        m.stop();
    endtask
    // One byte read at the current pointer
    task automatic rd(input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        m.start();
        m.wr_byte({srs_pkg::ADDR_STD, 1'b1}, a);
        check(a, 1'b1);
        m.rd_byte(d);
        m.stop();
        check(d, exp);
    endtask
    // Defaults read through read addresses
    task automatic t_defaults();
        xfer_w(8'h04, 8'h00, 1'b0);
        rd(8'h08);
        xfer_w(8'hFE, 8'h00, 1'b0);
        rd(srs_pkg::ID_VALUE);
        xfer_w(8'h10, 8'h00, 1'b0);
        rd(sense.remote_lo);
        xfer_w(8'h22, 8'h00, 1'b0);
        rd(8'h01);
        check(ten, 1'b0);
        $display("test defaults done");
    endtask
    // Write via write address, read back via read address
    task automatic t_split();
        xfer_w(8'h0B, 8'h33, 1'b1);
        check(wr_cnt, 1);
        check({last_wr.addr, last_wr.data}, 16'h0B33);
        xfer_w(8'h05, 8'h00, 1'b0);
        rd(8'h33);
        rd(8'h33);
        xfer_w(8'h05, 8'h77, 1'b1);
        check(wr_cnt, 1);
        rd(8'h33);
        xfer_w(8'h0B, 8'h00, 1'b0);
        rd(8'h00);
        $display("test split done");
    endtask
    // Strobe address gives a pulse and stores nothing
    task automatic t_oneshot();
        xfer_w(8'h0F, 8'hAA, 1'b1);
        check(os_cnt, 1);
        check(wr_cnt, 1);
        $display("test oneshot done");
    endtask
    // Foreign address ignored, third write byte refused
    task automatic t_refuse();
        logic a;
        m.start();
        m.wr_byte({srs_pkg::ADDR_ALT, 1'b0}, a);
        check(a, 1'b0);
        m.wr_byte(8'h0B, a);
        check(a, 1'b0);
        m.stop();
        m.start();
        m.wr_byte({srs_pkg::ADDR_STD, 1'b0}, a);
        m.wr_byte(8'h0B, a);
        m.wr_byte(8'h44, a);
        m.wr_byte(8'h55, a);
        check(a, 1'b0);
        m.stop();
        check(wr_cnt, 2);
        xfer_w(8'h05, 8'h00, 1'b0);
        rd(8'h44);
        xfer_w(8'h02, 8'h00, 1'b0);
        rd(sense.status);
        $display("test refuse done");
    endtask
    // Stalled ack dropped only while the timeout is enabled
    task automatic t_timeout();
        logic a;
        xfer_w(8'h22, 8'h81, 1'b1);
        check(ten, 1'b1);
        m.start();
        m.stall({srs_pkg::ADDR_STD, 1'b0}, 8000);
        check(dut_oe, 1'b0);
        m.stop();
        rd(8'h81);
        xfer_w(8'h22, 8'h01, 1'b1);
        check(ten, 1'b0);
        m.start();
        m.stall({srs_pkg::ADDR_STD, 1'b0}, 8000);
        check(dut_oe, 1'b1);
        m.pulse(1'b1, a);
        check(a, 1'b0);
        m.stop();
        $display("test timeout done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        sense = {8'h19, 8'h2A, 8'h80, 8'hC0};
        fails = 0;
        compares = 0;
        wr_cnt = 0;
        os_cnt = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_split();
        t_oneshot();
        t_refuse();
        t_timeout();
        final_report();
    end
    // Watchdog well past the expected run time
    initial begin
        #1_000_000;
        fails++;
        final_report();
    end
endmodule

bind srs_slave srs_slave_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus_clock_line_i(bus_clock_line_i),
    .bus_data_line_i(bus_data_line_i), .bus_data_line_o(bus_data_line_o),
    .bus_data_line_oe(bus_data_line_oe), .one_shot_q(one_shot_q), .wr_q(wr_q),
    .timeout_en_q(timeout_en_q));
